//--- rtl/pcac_map.vh
// Operation
// R01 - centre mode counts up and down; direction forced up at count zero
// R02 - centre mode: up-count equal to duty toggles the output flip-flop
// R03 - centre mode: count equal to period turns direction from up to down
// R04 - centre mode: down-count equal to duty toggles the output again
// R05 - centre mode: down-count reaching zero turns up and loads buffers
// R06 - centre mode runs zero to period and back, twice the period
// R07 - software picks alignment before enabling a channel
// R08 - eight 8-bit channels or four 16-bit paired channels
// R09 - four pairing bits join 0-1, 2-3, 4-5 and 6-7
// R10 - software changes a pairing bit only with both channels disabled
// R11 - in a pair the even channel holds the upper byte
// R12 - in a pair the odd channel's clock select picks the clock
// R13 - in a pair the odd pin carries the waveform with odd polarity
// R14 - in a pair only odd enable counts; even output held disabled
// R15 - any write to either byte of a paired counter clears it all
// R16 - software reads a paired counter with one 16-bit access
// R17 - in a pair the odd alignment bit selects the mode
// R18 - duty zero gives the inactive level; duty at or over period active
// R19 - period zero holds the counter at zero, output at polarity level
// R20 - polarity one starts high and drops at duty match, else inverse
// R21 - period and duty double buffered when enabled, direct when disabled
// R22 - counter write clears count, sets up, loads buffers, sets output
// R23 - disabled counter stops and resumes from its held value
// R24 - paired counter, period and duty act as single 16-bit values
`ifndef PCAC_MAP_VH
`define PCAC_MAP_VH
`define PCAC_ADDR_W      8
`define PCAC_OFS_ENABLE  8'h00
`define PCAC_OFS_POL     8'h04
`define PCAC_OFS_CLKSEL  8'h08
`define PCAC_OFS_ALIGN   8'h0c
`define PCAC_OFS_CTRL    8'h10
`define PCAC_OFS_SCALE   8'h14
`define PCAC_OFS_OUTSTAT 8'h18
`define PCAC_IDX_CNT0    6'h08
`define PCAC_IDX_PER0    6'h10
`define PCAC_IDX_DTY0    6'h18
`define PCAC_RST_BYTE    8'h00
`define PCAC_RST_SCALE   8'h01
`define PCAC_RESP_OKAY   2'b00
`define PCAC_RESP_SLVERR 2'b10
`endif

//--- rtl/pcac_tick.v
`timescale 1ns/1ps
`default_nettype none
module pcac_tick (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [7:0] scale,
  output reg        tick_q
);
  reg [7:0] div_q;
  // scaled clock: one tick every scale+1 bus cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q >= scale) begin
      div_q  <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end
endmodule // pcac_tick
`default_nettype wire

//--- rtl/pcac_chan.v
`timescale 1ns/1ps
`default_nettype none
module pcac_chan (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        tick,
  input  wire        run,
  input  wire        center,
  input  wire        pol,
  input  wire [15:0] per_buf,
  input  wire [15:0] dty_buf,
  input  wire        cnt_clr,
  output reg         out_q,
  output reg  [15:0] cnt_q
);
  reg  [15:0] per_a_q;
  reg  [15:0] dty_a_q;
  reg         down_q;
  reg         phase_q;
  wire [15:0] nxt_up = cnt_q + 16'h0001;
  wire [15:0] nxt_dn = cnt_q - 16'h0001;
  wire        going_down = down_q & (cnt_q != 16'h0000); // R01
  reg         after;

  // boundary levels override the toggling flip-flop
  always @* begin
    if (per_a_q == 16'h0000)
      after = 1'b0; // R19
    else if (dty_a_q == 16'h0000)
      after = 1'b1; // R18
    else if (dty_a_q >= per_a_q)
      after = 1'b0; // R18
    else
      after = phase_q;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= 16'h0000;
      per_a_q <= 16'h0000;
      dty_a_q <= 16'h0000;
      down_q  <= 1'b0;
      phase_q <= 1'b0;
      out_q   <= 1'b0;
    end else begin
      out_q <= run & (pol ^ after); // R20 R13 R14
      if (cnt_clr) begin
        cnt_q   <= 16'h0000; // R22 R15
        down_q  <= 1'b0;
        phase_q <= 1'b0;
        per_a_q <= per_buf;
        dty_a_q <= dty_buf;
      end else if (!run) begin
        per_a_q <= per_buf; // R21 R23
        dty_a_q <= dty_buf;
      end else if (tick) begin
        if (per_a_q == 16'h0000) begin
          cnt_q   <= 16'h0000; // R19
          down_q  <= 1'b0;
          phase_q <= 1'b0;
          per_a_q <= per_buf;
          dty_a_q <= dty_buf;
        end else if (!center) begin
          if (nxt_up >= per_a_q) begin
            cnt_q   <= 16'h0000;
            phase_q <= 1'b0;
            per_a_q <= per_buf;
            dty_a_q <= dty_buf;
          end else begin
            cnt_q <= nxt_up;
            if (nxt_up == dty_a_q)
              phase_q <= ~phase_q;
          end
        end else if (!going_down) begin
          if (cnt_q >= per_a_q) begin
            down_q <= 1'b1; // R03
            cnt_q  <= nxt_dn;
            if (nxt_dn == dty_a_q)
              phase_q <= ~phase_q; // R04
          end else begin
            down_q <= 1'b0; // R01
            cnt_q  <= nxt_up; // R06 R24
            if (nxt_up == dty_a_q)
              phase_q <= ~phase_q; // R02
          end
        end else begin
          cnt_q <= nxt_dn;
          if (nxt_dn == 16'h0000) begin
            down_q  <= 1'b0; // R05
            phase_q <= 1'b0;
            per_a_q <= per_buf;
            dty_a_q <= dty_buf;
          end else if (nxt_dn == dty_a_q) begin
            phase_q <= ~phase_q; // R04
          end
        end
      end
    end
  end
endmodule // pcac_chan
`default_nettype wire

//--- rtl/pcac_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pcac_map.vh"
module pcac_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [7:0]  pwm_out
);
  reg  [7:0]  channel_enable_bit_q;
  reg  [7:0]  output_polarity_bit_q;
  reg  [7:0]  clock_select_bit_q;
  reg  [7:0]  center_align_bit_q;
  reg  [3:0]  pair_bits_q;
  reg  [7:0]  scale_q;
  reg  [7:0]  per_q [0:7];
  reg  [7:0]  dty_q [0:7];
  reg  [7:0]  cnt_wr_q;
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  wire [127:0] cnt_all;
  wire        scaled_tick;
  wire [5:0]  w_idx = awaddr_q[7:2];
  wire [5:0]  r_idx = s_axi_araddr[7:2];
  integer     k;

  pcac_tick u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .scale   (scale_q),
    .tick_q  (scaled_tick)
  );

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_ch // R08
      wire        paired = pair_bits_q[i/2]; // R09
      wire        run;
      wire [15:0] per_v;
      wire [15:0] dty_v;
      wire        clr;
      if ((i % 2) == 0) begin : g_even
        assign run   = channel_enable_bit_q[i] & ~paired; // R14
        assign per_v = {8'h00, per_q[i]};
        assign dty_v = {8'h00, dty_q[i]};
        assign clr   = cnt_wr_q[i];
      end else begin : g_odd
        assign run   = channel_enable_bit_q[i]; // R14
        assign per_v = paired ? {per_q[i-1], per_q[i]} // R11 R24
                              : {8'h00, per_q[i]};
        assign dty_v = paired ? {dty_q[i-1], dty_q[i]} // R11 R24
                              : {8'h00, dty_q[i]};
        assign clr   = cnt_wr_q[i] | (paired & cnt_wr_q[i-1]); // R15
      end
      pcac_chan u_chan (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (clock_select_bit_q[i] ? scaled_tick : 1'b1), // R12
        .run     (run),
        .center  (center_align_bit_q[i]), // R17
        .pol     (output_polarity_bit_q[i]), // R13
        .per_buf (per_v),
        .dty_buf (dty_v),
        .cnt_clr (clr),
        .out_q   (pwm_out[i]),
        .cnt_q   (cnt_all[16*i +: 16])
      );
    end
  endgenerate

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PCAC_RESP_OKAY;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      cnt_wr_q      <= 8'h00;
      channel_enable_bit_q  <= `PCAC_RST_BYTE;
      output_polarity_bit_q <= `PCAC_RST_BYTE;
      clock_select_bit_q    <= `PCAC_RST_BYTE;
      center_align_bit_q    <= `PCAC_RST_BYTE;
      pair_bits_q           <= 4'h0;
      scale_q               <= `PCAC_RST_SCALE;
      for (k = 0; k < 8; k = k + 1) begin
        per_q[k] <= `PCAC_RST_BYTE;
        dty_q[k] <= `PCAC_RST_BYTE;
      end
    end else begin
      cnt_wr_q      <= 8'h00;
      s_axi_awready <= ~aw_got_q & ~s_axi_awready & ~s_axi_bvalid
                       & s_axi_awvalid;
      s_axi_wready  <= ~w_got_q & ~s_axi_wready & ~s_axi_bvalid
                       & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (aw_got_q & w_got_q & ~s_axi_bvalid) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PCAC_RESP_OKAY;
        // a counter write clears whatever the strobes say
        if (w_idx >= `PCAC_IDX_CNT0 && w_idx < `PCAC_IDX_CNT0 + 6'h08)
          cnt_wr_q[w_idx[2:0]] <= 1'b1; // R22 R15
        else if (w_idx >= `PCAC_IDX_PER0 &&
                 w_idx < `PCAC_IDX_PER0 + 6'h08) begin
          if (wstrb_q[0])
            per_q[w_idx[2:0]] <= wdata_q[7:0]; // R21
        end else if (w_idx >= `PCAC_IDX_DTY0 &&
                     w_idx < `PCAC_IDX_DTY0 + 6'h08) begin
          if (wstrb_q[0])
            dty_q[w_idx[2:0]] <= wdata_q[7:0]; // R21
        end else if (wstrb_q[0]) begin
          case (awaddr_q)
            `PCAC_OFS_ENABLE: channel_enable_bit_q  <= wdata_q[7:0];
            `PCAC_OFS_POL:    output_polarity_bit_q <= wdata_q[7:0];
            `PCAC_OFS_CLKSEL: clock_select_bit_q    <= wdata_q[7:0];
            `PCAC_OFS_ALIGN:  center_align_bit_q    <= wdata_q[7:0];
            `PCAC_OFS_CTRL:   pair_bits_q           <= wdata_q[3:0];
            `PCAC_OFS_SCALE:  scale_q               <= wdata_q[7:0];
            default:          s_axi_bresp <= `PCAC_RESP_SLVERR;
          endcase
        end else if (awaddr_q > `PCAC_OFS_OUTSTAT ||
                     awaddr_q[1:0] != 2'b00) begin
          s_axi_bresp <= `PCAC_RESP_SLVERR;
        end
      end
    end
  end

  // read data mux
  reg [31:0] rd_v;
  reg        rd_err;
  always @* begin
    rd_v   = 32'h00000000;
    rd_err = 1'b0;
    if (r_idx >= `PCAC_IDX_CNT0 && r_idx < `PCAC_IDX_CNT0 + 6'h08) begin
      // paired even reads the upper byte, paired odd the full word
      if (~r_idx[0] & pair_bits_q[r_idx[2:1]])
        rd_v = {24'h000000, cnt_all[16*(r_idx[2:0]+3'h1)+8 +: 8]};
      else if (r_idx[0] & pair_bits_q[r_idx[2:1]])
        rd_v = {16'h0000, cnt_all[16*r_idx[2:0] +: 16]};
      else
        rd_v = {24'h000000, cnt_all[16*r_idx[2:0] +: 8]};
    end else if (r_idx >= `PCAC_IDX_PER0 &&
                 r_idx < `PCAC_IDX_PER0 + 6'h08)
      rd_v = {24'h000000, per_q[r_idx[2:0]]};
    else if (r_idx >= `PCAC_IDX_DTY0 && r_idx < `PCAC_IDX_DTY0 + 6'h08)
      rd_v = {24'h000000, dty_q[r_idx[2:0]]};
    else begin
      case (s_axi_araddr)
        `PCAC_OFS_ENABLE:  rd_v = {24'h000000, channel_enable_bit_q};
        `PCAC_OFS_POL:     rd_v = {24'h000000, output_polarity_bit_q};
        `PCAC_OFS_CLKSEL:  rd_v = {24'h000000, clock_select_bit_q};
        `PCAC_OFS_ALIGN:   rd_v = {24'h000000, center_align_bit_q};
        `PCAC_OFS_CTRL:    rd_v = {28'h0000000, pair_bits_q};
        `PCAC_OFS_SCALE:   rd_v = {24'h000000, scale_q};
        `PCAC_OFS_OUTSTAT: rd_v = {24'h000000, pwm_out};
        default:           rd_err = 1'b1;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PCAC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_err ? 32'h00000000 : rd_v;
        s_axi_rresp  <= rd_err ? `PCAC_RESP_SLVERR : `PCAC_RESP_OKAY;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // pcac_top
`default_nettype wire

//--- dv/pcac_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pcac_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [7:0]  pwm_out
);
  // shadow of the byte registers, fed from accepted writes
  logic [7:0] sh [0:31];
  logic [5:0] quiet_q;
  logic [7:0] len_q;
  logic       p2_q;
  logic       wr;
  logic       st;
  logic [7:0] per;
  logic [7:0] dty;
  assign wr  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign per = sh[18];
  assign dty = sh[26];
  assign st  = sh[0][2] && !sh[4][1] && quiet_q > 6'd8;
  always @(posedge aclk) begin
    p2_q <= pwm_out[2];
    len_q <= (pwm_out[2] != p2_q) ? 8'h01 : len_q + {7'h00, len_q != 8'hff};
    if (!aresetn) begin
      quiet_q <= 6'h00;
      sh <= '{default: 8'h00};
    end else if (wr) begin
      quiet_q <= 6'h00;
      sh[s_axi_awaddr[6:2]] <= s_axi_wdata[7:0];
    end else if (quiet_q != 6'h3f) begin
      quiet_q <= quiet_q + 6'h01;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cnt2_wr;
    wr && s_axi_awaddr == 8'h28;
  endsequence
  // long quiet so the last edge also came from settled settings
  sequence s_steady;
    st && quiet_q == 6'h3f && sh[3][2] && !sh[2][2] && dty != 8'h00
      && dty < per && per < 8'h10;
  endsequence
  AST_DUTY_ZERO: assert property (st && per != 8'h00 && dty == 8'h00
    |-> pwm_out[2] == !sh[1][2]) else $error("duty zero level wrong");
  AST_DUTY_FULL: assert property (st && per != 8'h00 && dty >= per
    |-> pwm_out[2] == sh[1][2]) else $error("full duty level wrong");
  AST_NO_PERIOD: assert property (st && per == 8'h00
    |-> pwm_out[2] == sh[1][2]) else $error("zero period level wrong");
  AST_PAIR_HI_OFF: assert property (quiet_q > 6'd8 && sh[4][0]
    |-> !pwm_out[0]) else $error("paired even pin not held off");
  AST_PAIR_LO_EN: assert property (sh[4][0] && !sh[0][1]
    && quiet_q > 6'd8 |-> !pwm_out[1])
    else $error("pair runs without odd enable");
  AST_CNT_WR_POL: assert property (s_cnt2_wr ##0 (sh[0][2] && !sh[4][1]
    && dty >= 8'd6 && per > dty) |-> ##4 pwm_out[2] == sh[1][2])
    else $error("counter write did not restart at polarity level");
  AST_RISE_LEN: assert property (s_steady ##0 $rose(pwm_out[2])
    |-> {1'b0, len_q} == (sh[1][2] ? {per - dty, 1'b0} : {dty, 1'b0}))
    else $error("low segment length wrong");
  AST_FALL_LEN: assert property (s_steady ##0 $fell(pwm_out[2])
    |-> {1'b0, len_q} == (sh[1][2] ? {dty, 1'b0} : {per - dty, 1'b0}))
    else $error("high segment length wrong");
endmodule // pcac_chk
`default_nettype wire

//--- dv/pcac_load.sv
`timescale 1ns/1ps
`default_nettype none
module pcac_load (
  input  wire logic        aclk,
  input  wire logic [7:0]  pins,
  input  wire logic [2:0]  sel,
  input  wire logic        clr,
  output var  logic [15:0] hi_cnt
);
  // passive load: counts high cycles, never drives the pins
  always @(posedge aclk) begin
    if (clr) begin
      hi_cnt <= 16'h0000;
    end else if (pins[sel] === 1'b1) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end
endmodule // pcac_load
`default_nettype wire

//--- dv/pwm_center_align_concat_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcac_map.vh"
module pwm_center_align_concat_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, clr;
  logic [7:0]  awaddr, araddr, pwm_out;
  logic [31:0] wdata, rdata, v, v0;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  sel;
  logic [15:0] hi_cnt;
  int          n_fail, n_checks;
  logic [7:0]  tpol = 8'h5a;
  logic [7:0]  tper [8] = '{10, 10, 10, 10, 10, 0, 0, 10};
  logic [7:0]  tdty [8] = '{6, 6, 0, 0, 12, 3, 3, 10};
  logic [15:0] texp [8] = '{32, 48, 80, 0, 80, 0, 80, 0};
  pcac_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pwm_out(pwm_out));
  pcac_load u_load (.aclk(aclk), .pins(pwm_out), .sel(sel), .clr(clr),
    .hi_cnt(hi_cnt));
  function automatic logic [7:0] ra(input logic [5:0] b, input logic [5:0] n);
    return {b + n, 2'b00};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // fixed settle, then a window of whole waveform periods
  task automatic meas(input logic [2:0] s, input int w, input logic [15:0] e);
    sel <= s;
    repeat (70) @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (w + 1) @(posedge aclk);
    chk({16'h0, hi_cnt}, {16'h0, e});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = 7'h00;
    {awaddr, araddr, wdata, sel} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PCAC_OFS_SCALE);
    chk(v, 32'h1);
    rd(8'h1c);
    chk({30'h0, r}, {30'h0, `PCAC_RESP_SLVERR});
    wr(`PCAC_OFS_ALIGN, 32'h06);
    chk({30'h0, r}, {30'h0, `PCAC_RESP_OKAY});
    wr(8'h1c, 32'h0);
    chk({30'h0, r}, {30'h0, `PCAC_RESP_SLVERR});
    for (int i = 0; i < 8; i++) begin
      wr(`PCAC_OFS_ENABLE, 32'h0);
      wr(`PCAC_OFS_POL, {29'h0, tpol[i], 2'b00});
      wr(ra(`PCAC_IDX_PER0, 2), {24'h0, tper[i]});
      wr(ra(`PCAC_IDX_DTY0, 2), {24'h0, tdty[i]});
      wr(`PCAC_OFS_ENABLE, 32'h04);
      wr(ra(`PCAC_IDX_CNT0, 2), 32'h0);
      meas(3'd2, 80, texp[i]);
    end
    wr(`PCAC_OFS_ENABLE, 32'h0);
    rd(ra(`PCAC_IDX_CNT0, 2));
    v0 = v;
    // odd gap: a running triangle count cannot repeat its value here
    repeat (31) @(posedge aclk);
    rd(ra(`PCAC_IDX_CNT0, 2));
    chk(v, v0);
    wr(ra(`PCAC_IDX_CNT0, 2), 32'h5a);
    repeat (30) @(posedge aclk);
    rd(ra(`PCAC_IDX_CNT0, 2));
    chk(v, 32'h0);
    wr(`PCAC_OFS_CTRL, 32'h1);
    wr(`PCAC_OFS_POL, 32'h1);
    wr(`PCAC_OFS_CLKSEL, 32'h1);
    wr(ra(`PCAC_IDX_PER0, 0), 32'h1);
    wr(ra(`PCAC_IDX_DTY0, 1), 32'h40);
    wr(`PCAC_OFS_ENABLE, 32'h1);
    meas(3'd1, 512, 16'd0);
    wr(`PCAC_OFS_ENABLE, 32'h3);
    meas(3'd1, 512, 16'd384);
    meas(3'd0, 512, 16'd0);
    // odd select on the scaled tick halves the pair's rate
    wr(`PCAC_OFS_CLKSEL, 32'h2);
    meas(3'd1, 1024, 16'd768);
    wr(`PCAC_OFS_ENABLE, 32'h1);
    wr(ra(`PCAC_IDX_CNT0, 0), 32'h0);
    rd(ra(`PCAC_IDX_CNT0, 1));
    chk(v, 32'h0);
    rd(`PCAC_OFS_OUTSTAT);
    chk(v, 32'h0);
    tally_and_finish();
  end
endmodule // pwm_center_align_concat_tb
bind pcac_top pcac_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .pwm_out(pwm_out));
`default_nettype wire
